// File: design/nvmwc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Function
// - flash busy sets on first latched address, or on launch for erase-all
// - flash busy: reads return FFh, writes ignored
// - flash busy clears at end or suspend, sets again on resume
// - flash busy held up to 10 us after power-up and power-down exit
// - eeprom launch bit starts work, cleared by hardware, software zero ignored
// - page update takes 1..16 bytes of one page, clears select at end
// - erase-all select plus launch erases both sectors, select cleared at end
// - wait instr: standby if select zero, power-down with recovery if one
// - low-power entry deferred until any write completes
// - irq source select picks external pin or end-of-write event
// - eeprom busy sets on first page address or erase launch, clears at end
// - eeprom busy: reads return FFh, page bytes still latched until launch, writes ignored after
// - eeprom busy held up to 10 ms after power-up and power-down exit
// - write fault sets on any failure, software clear also clears detail flags
// - sector flags show error, write in progress or suspended erase
// - erase fault sets on cell erase failure
// - program fault sets on cell program failure
// - flash programming a zero back to one sets swap/overwrite fault, except with flash_prot_prog_i
// - eeprom swap failure sets swap fault and skips old-sector erase
// - clearing select before launch cancels and drops latched data
// ****************************************
module nvmwc_ctrl #(
    parameter int FLASH_WAKE  = nvmwc_pkg::FLASH_WAKE_CYC,
    parameter int EEPROM_WAKE = nvmwc_pkg::EEPROM_WAKE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // processor memory port
    input  wire logic [23:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    // array side
    input  wire logic [7:0]  flash_rdata_i,
    input  wire logic [7:0]  eeprom_rdata_i,
    output logic             flash_wr_o,
    output logic             eeprom_wr_o,
    output logic      [7:0]  page_data_o,
    output logic      [3:0]  page_idx_o,
    output logic             eeprom_erase_all_o,
    output logic             eeprom_start_o,
    // flash engine status
    input  wire logic        flash_addr_latched_i,
    input  wire logic        flash_erase_all_go_i,
    input  wire logic        flash_op_done_i,
    input  wire logic        erase_suspend_req_i,
    input  wire logic        erase_resume_i,
    input  wire logic        flash_overwrite_i,
    input  wire logic        flash_prot_prog_i,
    // eeprom engine status
    input  wire logic        eeprom_op_done_i,
    input  wire logic        swap_fail_i,
    // cell results, shared
    input  wire logic        erase_fail_i,
    input  wire logic        program_fail_i,
    input  wire logic [6:0]  sector_hit_i,
    // power and interrupts
    input  wire logic        wait_for_irq_instr_i,
    input  wire logic        halt_stop_i,
    input  wire logic        wake_i,
    input  wire logic        ext_irq_pin_i,
    output logic             shared_irq_channel_o,
    output logic             flash_standby_o,
    output logic             flash_powerdown_o,
    output logic             skip_old_erase_o,
    output logic             flash_op_active_o,
    output logic             eeprom_op_active_o
);
    // ****************************************
    // state
    // ****************************************
    logic [7:0]  ecr_reg;
    logic        flash_busy_reg;
    logic        eeprom_busy_reg;
    logic        ee_run_reg;
    logic        fault_reg;
    logic [6:0]  sector_reg;
    logic [2:0]  detail_reg;
    logic [31:0] fwake_reg;
    logic [31:0] ewake_reg;
    logic        skip_reg;
    logic [1:0]  pin_sync_reg;
    logic        halt_reg;
    logic [7:0]  rdata_reg;
    nvmwc_pkg::nvmwc_pwr_t pwr_reg;

    nvmwc_page_if pg ();

    nvmwc_page_buf #(.DEPTH(nvmwc_pkg::PAGE_BYTES)) u_buf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pg      (pg.buf_side)
    );

    // ****************************************
    // decode
    // ****************************************
    logic in_flash;
    logic in_eeprom;
    logic ecr_wr;
    logic st0_wr;
    logic ee_wr;
    logic fault_clr;
    logic ee_cancel;
    logic ee_done;
    logic f_wake_busy;
    logic e_wake_busy;
    logic any_write;

    assign in_flash  = addr_i <= nvmwc_pkg::FLASH_HI_ADDR;
    assign in_eeprom = addr_i >= nvmwc_pkg::EEPROM_LO_ADDR && addr_i <= nvmwc_pkg::EEPROM_HI_ADDR;
    assign ecr_wr    = wr_i && addr_i == nvmwc_pkg::EEPROM_CONTROL_ADDR;
    assign st0_wr    = wr_i && addr_i == nvmwc_pkg::STATUS_PRIMARY_ADDR;
    // latch phase keeps taking bytes; only a running operation or wake-up refuses them
    assign ee_wr     = wr_i && in_eeprom && !ee_run_reg && !e_wake_busy &&
                       ecr_reg[nvmwc_pkg::ECR_PAGE_BIT];
    assign fault_clr = st0_wr && !wdata_i[nvmwc_pkg::ST0_FAULT_BIT];
    assign ee_done   = ee_run_reg && eeprom_op_done_i;
    assign f_wake_busy = fwake_reg != 32'h00000000;
    assign e_wake_busy = ewake_reg != 32'h00000000;
    assign any_write = flash_busy_reg || ee_run_reg;

    assign pg.wr     = ee_wr;
    assign pg.idx    = addr_i[3:0];
    assign pg.data   = wdata_i;
    assign pg.rd_idx = addr_i[3:0];
    // dropping latched bytes when select falls before launch
    assign ee_cancel = ecr_wr && !wdata_i[nvmwc_pkg::ECR_PAGE_BIT] && !ee_run_reg;
    assign pg.clr    = ee_cancel || ee_done;

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ecr_reg    <= nvmwc_pkg::ECR_RESET;
            ee_run_reg <= 1'b0;
        end else begin
            if (ecr_wr) begin
                ecr_reg[nvmwc_pkg::ECR_WAITPWR_BIT] <= wdata_i[nvmwc_pkg::ECR_WAITPWR_BIT];
                ecr_reg[nvmwc_pkg::ECR_IRQSEL_BIT]  <= wdata_i[nvmwc_pkg::ECR_IRQSEL_BIT];
                if (!ee_run_reg) begin
                    ecr_reg[nvmwc_pkg::ECR_PAGE_BIT]  <= wdata_i[nvmwc_pkg::ECR_PAGE_BIT];
                    ecr_reg[nvmwc_pkg::ECR_ERASE_BIT] <= wdata_i[nvmwc_pkg::ECR_ERASE_BIT];
                end
                // zero writes never abort a running operation
                if (wdata_i[nvmwc_pkg::ECR_LAUNCH_BIT] && !ee_run_reg && !flash_busy_reg) begin
                    ecr_reg[nvmwc_pkg::ECR_LAUNCH_BIT] <= 1'b1;
                    ee_run_reg <= 1'b1;
                end
            end
            if (ee_done) begin
                ecr_reg[nvmwc_pkg::ECR_LAUNCH_BIT] <= 1'b0;
                ecr_reg[nvmwc_pkg::ECR_PAGE_BIT]   <= 1'b0;
                ecr_reg[nvmwc_pkg::ECR_ERASE_BIT]  <= 1'b0;
                ee_run_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // busy flags and wake timers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flash_busy_reg <= 1'b0;
        end else if (flash_addr_latched_i || flash_erase_all_go_i || erase_resume_i) begin
            flash_busy_reg <= 1'b1;
        end else if (flash_op_done_i || erase_suspend_req_i) begin
            flash_busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            eeprom_busy_reg <= 1'b0;
        end else if ((ee_wr && pg.valid == 16'h0000) ||
                     (ecr_wr && wdata_i[nvmwc_pkg::ECR_LAUNCH_BIT] &&
                      ecr_reg[nvmwc_pkg::ECR_ERASE_BIT] && !ee_run_reg && !flash_busy_reg)) begin
            eeprom_busy_reg <= 1'b1;
        end else if (ee_done || ee_cancel) begin
            eeprom_busy_reg <= 1'b0;
        end
    end

    // counters reload at power-up and at each power-down exit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fwake_reg <= FLASH_WAKE;
            ewake_reg <= EEPROM_WAKE;
        end else if (pwr_reg == nvmwc_pkg::NVMWC_PWR_DOWN && wake_i) begin
            fwake_reg <= FLASH_WAKE;
            ewake_reg <= EEPROM_WAKE;
        end else begin
            if (f_wake_busy) fwake_reg <= fwake_reg - 32'h00000001;
            if (e_wake_busy) ewake_reg <= ewake_reg - 32'h00000001;
        end
    end

    // ****************************************
    // low power
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_reg  <= nvmwc_pkg::NVMWC_PWR_RUN;
            halt_reg <= 1'b0;
        end else begin
            case (pwr_reg)
                nvmwc_pkg::NVMWC_PWR_RUN: begin
                    if (wait_for_irq_instr_i || halt_stop_i) begin
                        pwr_reg  <= nvmwc_pkg::NVMWC_PWR_WAIT;
                        // halt is a pulse, remembered across the deferral
                        halt_reg <= halt_stop_i;
                    end
                end
                nvmwc_pkg::NVMWC_PWR_WAIT: begin
                    if (wake_i) begin
                        pwr_reg <= nvmwc_pkg::NVMWC_PWR_RUN;
                    end else if (!any_write) begin
                        pwr_reg <= (ecr_reg[nvmwc_pkg::ECR_WAITPWR_BIT] || halt_reg) ?
                                   nvmwc_pkg::NVMWC_PWR_DOWN : nvmwc_pkg::NVMWC_PWR_STANDBY;
                    end
                end
                nvmwc_pkg::NVMWC_PWR_STANDBY,
                nvmwc_pkg::NVMWC_PWR_DOWN: begin
                    if (wake_i) pwr_reg <= nvmwc_pkg::NVMWC_PWR_RUN;
                end
                default: pwr_reg <= nvmwc_pkg::NVMWC_PWR_RUN;
            endcase
        end
    end

    // ****************************************
    // status registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_reg  <= 1'b0;
            detail_reg <= 3'h0;
            sector_reg <= 7'h00;
        end else begin
            // set beats a same-cycle software clear
            fault_reg <= (fault_reg && !fault_clr) || erase_fail_i || program_fail_i ||
                         swap_fail_i || flash_overwrite_i;
            detail_reg[2] <= (detail_reg[2] && !fault_clr) || erase_fail_i;
            detail_reg[1] <= (detail_reg[1] && !fault_clr) || program_fail_i;
            detail_reg[0] <= (detail_reg[0] && !fault_clr) || swap_fail_i ||
                             (flash_overwrite_i && !flash_prot_prog_i);
            // sector bits only move by hardware; bus writes are dropped
            if (sector_hit_i != 7'h00) sector_reg <= sector_hit_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || ee_done) begin
            skip_reg <= 1'b0;
        end else if (swap_fail_i && ee_run_reg) begin
            skip_reg <= 1'b1;
        end
    end

    // ****************************************
    // read mux and pin sync
    // ****************************************
    logic fl_block;
    logic ee_block;
    assign fl_block = flash_busy_reg || f_wake_busy;
    assign ee_block = eeprom_busy_reg || e_wake_busy;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            if (in_flash)
                rdata_reg <= fl_block ? nvmwc_pkg::ERASED_BYTE : flash_rdata_i;
            else if (in_eeprom)
                rdata_reg <= ee_block ? nvmwc_pkg::ERASED_BYTE : eeprom_rdata_i;
            else if (addr_i == nvmwc_pkg::EEPROM_CONTROL_ADDR)
                rdata_reg <= {ecr_reg[7:1], ee_block};
            else if (addr_i == nvmwc_pkg::STATUS_PRIMARY_ADDR)
                rdata_reg <= {fault_reg, sector_reg};
            else if (addr_i == nvmwc_pkg::ERROR_DETAIL_ADDR)
                rdata_reg <= {detail_reg, 5'h00};
            else
                rdata_reg <= 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) pin_sync_reg <= 2'h0;
        else pin_sync_reg <= {pin_sync_reg[0], ext_irq_pin_i};
    end

    assign rdata_o              = rdata_reg;
    assign flash_wr_o           = wr_i && in_flash && !fl_block;
    assign eeprom_wr_o          = ee_wr;
    assign page_data_o          = pg.rd_data;
    assign page_idx_o           = addr_i[3:0];
    assign eeprom_erase_all_o   = ecr_reg[nvmwc_pkg::ECR_ERASE_BIT];
    assign eeprom_start_o       = ee_run_reg;
    assign shared_irq_channel_o = ecr_reg[nvmwc_pkg::ECR_IRQSEL_BIT] ?
                                  (ee_done || flash_op_done_i) : pin_sync_reg[1];
    assign flash_standby_o      = pwr_reg == nvmwc_pkg::NVMWC_PWR_STANDBY;
    assign flash_powerdown_o    = pwr_reg == nvmwc_pkg::NVMWC_PWR_DOWN;
    assign skip_old_erase_o     = skip_reg;
    assign flash_op_active_o    = fl_block;
    assign eeprom_op_active_o   = ee_block;

    // ****************************************
    // checks
    // ****************************************
    property p_flash_rd_ff;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && in_flash && fl_block |=> rdata_o == 8'hFF;
    endproperty
    a_flash_rd_ff: assert property (p_flash_rd_ff) else $error("flash read not FF");

    property p_ee_rd_ff;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && in_eeprom && ee_block |=> rdata_o == 8'hFF;
    endproperty
    a_ee_rd_ff: assert property (p_ee_rd_ff) else $error("eeprom read not FF");

    property p_done_clears;
        @(posedge clk_i) disable iff (!rst_n_i)
        ee_done |=> !ecr_reg[7] && !ecr_reg[6] && !ecr_reg[5];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("select not cleared");

    property p_fault_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        fault_clr && !erase_fail_i && !program_fail_i && !swap_fail_i && !flash_overwrite_i
        |=> fault_reg == 1'b0 && detail_reg == 3'h0;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault clear missed");

    property p_erase_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        erase_fail_i |=> detail_reg[2] && fault_reg;
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase fault lost");

    property p_prog_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        program_fail_i |=> detail_reg[1];
    endproperty
    a_prog_set: assert property (p_prog_set) else $error("program fault lost");

    property p_defer;
        @(posedge clk_i) disable iff (!rst_n_i)
        pwr_reg == nvmwc_pkg::NVMWC_PWR_WAIT && any_write && !wake_i
        |=> pwr_reg == nvmwc_pkg::NVMWC_PWR_WAIT;
    endproperty
    a_defer: assert property (p_defer) else $error("low power entered early");

    property p_irq_sel;
        @(posedge clk_i) disable iff (!rst_n_i)
        !ecr_reg[1] |-> shared_irq_channel_o == $past(ext_irq_pin_i, 2);
    endproperty
    a_irq_sel: assert property (p_irq_sel) else $error("irq source wrong");

    property p_suspend;
        @(posedge clk_i) disable iff (!rst_n_i)
        erase_suspend_req_i && !flash_addr_latched_i && !flash_erase_all_go_i && !erase_resume_i
        |=> !flash_busy_reg;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend kept busy");

    c_ee_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) ee_done);
    c_pdown: cover property (@(posedge clk_i) disable iff (!rst_n_i) flash_powerdown_o);
    c_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i) fault_clr && fault_reg);
endmodule
`default_nettype wire

// File: design/nvmwc_page_buf.sv
`timescale 1ns/1ps
`default_nettype none
// 16 byte page latch, registered read
module nvmwc_page_buf #(
    parameter int DEPTH = 16
) (
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    nvmwc_page_if.buf_side pg
);
    logic [7:0]       mem_reg [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [7:0]       rd_reg;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk_i) begin
                if (!rst_n_i || pg.clr) begin
                    valid_reg[g] <= 1'b0;
                end else if (pg.wr && pg.idx == 4'(g)) begin
                    valid_reg[g] <= 1'b1;
                    mem_reg[g]   <= pg.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= mem_reg[pg.rd_idx];
        end
    end

    assign pg.valid   = valid_reg;
    assign pg.rd_data = rd_reg;
endmodule
`default_nettype wire

// File: design/nvmwc_page_if.sv
`timescale 1ns/1ps
`default_nettype none
// page latch port between sequencer and buffer
interface nvmwc_page_if;
    logic       wr;
    logic [3:0] idx;
    logic [7:0] data;
    logic       clr;
    logic [15:0] valid;
    logic [7:0] rd_data;
    logic [3:0] rd_idx;
    modport ctl (output wr, idx, data, clr, rd_idx, input valid, rd_data);
    modport buf_side (input wr, idx, data, clr, rd_idx, output valid, rd_data);
endinterface
`default_nettype wire

// File: design/nvmwc_pkg.sv
package nvmwc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [23:0] FLASH_CTRL_ADDR     = 24'h224000;
    localparam logic [23:0] EEPROM_CONTROL_ADDR = 24'h224001;
    localparam logic [23:0] STATUS_PRIMARY_ADDR = 24'h224002;
    localparam logic [23:0] ERROR_DETAIL_ADDR   = 24'h224003;
    // ****************************************
    // array windows
    // ****************************************
    localparam logic [23:0] FLASH_LO_ADDR       = 24'h000000;
    localparam logic [23:0] FLASH_HI_ADDR       = 24'h01FFFF;
    localparam logic [23:0] EEPROM_LO_ADDR      = 24'h220000;
    localparam logic [23:0] EEPROM_HI_ADDR      = 24'h2203FF;
    // ****************************************
    // field positions
    // ****************************************
    localparam int ECR_LAUNCH_BIT   = 7;
    localparam int ECR_PAGE_BIT     = 6;
    localparam int ECR_ERASE_BIT    = 5;
    localparam int ECR_WAITPWR_BIT  = 2;
    localparam int ECR_IRQSEL_BIT   = 1;
    localparam int ECR_BUSY_BIT     = 0;
    localparam int ST0_FAULT_BIT    = 7;
    localparam int ST1_ERASE_BIT    = 7;
    localparam int ST1_PROG_BIT     = 6;
    localparam int ST1_SWAP_BIT     = 5;
    localparam logic [7:0] ECR_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;
    localparam int PAGE_BYTES           = 16;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ          = 250;
    localparam int FLASH_WAKE_US    = 10;
    localparam int EEPROM_WAKE_MS   = 10;
    localparam int FLASH_WAKE_CYC   = FLASH_WAKE_US * CLK_MHZ;
    localparam int EEPROM_WAKE_CYC  = EEPROM_WAKE_MS * 1000 * CLK_MHZ;
    typedef enum logic [1:0] {NVMWC_PWR_RUN, NVMWC_PWR_WAIT, NVMWC_PWR_STANDBY,
                              NVMWC_PWR_DOWN} nvmwc_pwr_t;
endpackage

// File: verification/nvmwc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// eeprom engine and array model
// ****************************************
module nvmwc_engine_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [23:0] addr_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  dly_i,
    output logic      [7:0]  flash_rdata_o,
    output logic      [7:0]  eeprom_rdata_o,
    output logic             done_o
);
    logic       run_reg;
    logic [7:0] cnt_reg;
    // data follows the address, so a stale byte never passes for a fresh one
    assign flash_rdata_o  = addr_i[7:0] ^ 8'h5A;
    assign eeprom_rdata_o = addr_i[7:0] ^ 8'hA5;
    // one done pulse per launch, after a prompt or slow delay
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            run_reg <= 1'b0;
        end else if (start_i && !run_reg && !done_o) begin
            run_reg <= 1'b1;
            cnt_reg <= dly_i;
        end else if (run_reg && cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else if (run_reg) begin
            done_o  <= 1'b1;
            run_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [23:0] EEPROM_CONTROL = nvmwc_pkg::EEPROM_CONTROL_ADDR;
    localparam logic [23:0] ST0 = nvmwc_pkg::STATUS_PRIMARY_ADDR;
    localparam logic [23:0] ST1 = nvmwc_pkg::ERROR_DETAIL_ADDR;
    localparam logic [23:0] FA  = 24'h000010;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, pin = 1'b0;
    logic [23:0] addr_i = 24'h000000, pa;
    logic [7:0]  wdata_i = 8'h00, dly = 8'h03, v, frd, erd, rdata_o;
    logic [12:0] ev = 13'h0000;
    logic [6:0]  sec = 7'h00;
    logic [31:0] seed = 32'h51FF;
    logic        fw, ew, fwr, ewr, eall, start, done, irq, stby, pdown, flash_op_active, eeprom_op_active, skip;
    int          mismatches = 0, n_checks = 0, cyc = 0, n;
    always #2 clk_i = ~clk_i;
    nvmwc_engine_model eng (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .start_i(start),
        .dly_i(dly), .flash_rdata_o(frd), .eeprom_rdata_o(erd), .done_o(done));
    nvmwc_ctrl #(.FLASH_WAKE(4), .EEPROM_WAKE(8)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .flash_rdata_i(frd), .eeprom_rdata_i(erd), .flash_wr_o(fwr), .eeprom_wr_o(ewr),
        .page_data_o(), .page_idx_o(), .eeprom_erase_all_o(eall), .eeprom_start_o(start),
        .flash_addr_latched_i(ev[0]), .flash_erase_all_go_i(ev[1]), .flash_op_done_i(ev[2]),
        .erase_suspend_req_i(ev[3]), .erase_resume_i(ev[4]), .flash_overwrite_i(ev[5]),
        .flash_prot_prog_i(ev[6]), .eeprom_op_done_i(done), .swap_fail_i(ev[7]),
        .erase_fail_i(ev[8]), .program_fail_i(ev[9]), .sector_hit_i(sec),
        .wait_for_irq_instr_i(ev[10]), .halt_stop_i(ev[11]), .wake_i(ev[12]),
        .ext_irq_pin_i(pin), .shared_irq_channel_o(irq), .flash_standby_o(stby),
        .flash_powerdown_o(pdown), .skip_old_erase_o(skip), .flash_op_active_o(flash_op_active),
        .eeprom_op_active_o(eeprom_op_active));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] dt);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= dt;
        wr_i <= 1'b1;
        #1;
        fw = fwr;
        ew = ewr;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [23:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic pulse(input int b);
        @(posedge clk_i);
        ev[b] <= 1'b1;
        @(posedge clk_i);
        ev[b] <= 1'b0;
        #1;
    endtask
    // bounded, the engine model answers within 34 cycles
    task automatic wait_idle;
        for (int k = 0; k < 300 && start !== 1'b0; k++) @(posedge clk_i);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("flash wake", 8'(flash_op_active), 8'h01);
        chk("eeprom wake", 8'(eeprom_op_active), 8'h01);
        repeat (12) @(posedge clk_i);
        #1;
        chk("flash ready", 8'(flash_op_active), 8'h00);
        chk("eeprom ready", 8'(eeprom_op_active), 8'h00);
        for (n = 1; n < 4; n++) begin
            rd(nvmwc_pkg::FLASH_CTRL_ADDR + 24'(n));
            chk("reg reset", v, 8'h00);
        end
        $display("test reset done");
        for (n = 0; n < 4; n++) begin
            seed = lfsr(seed);
            pa = nvmwc_pkg::EEPROM_LO_ADDR + {14'h0000, seed[9:4], 4'h0};
            dly <= (seed[7:0] & ((n[0]) ? 8'h1F : 8'h00)) | 8'h02;
            wr(EEPROM_CONTROL, 8'h40);
            wr(pa + 24'(seed[3:0]), seed[15:8]);
            chk("page accept", 8'(ew), 8'h01);
            chk("ee busy", 8'(eeprom_op_active), 8'h01);
            rd(pa);
            chk("ee busy read", v, 8'hFF);
            wr(pa, 8'h00);
            chk("page second byte", 8'(ew), 8'h01);
            wr(EEPROM_CONTROL, (n == 3) ? 8'h00 : 8'hC0);
            if (n == 3) begin
                chk("cancel", 8'(eeprom_op_active), 8'h00);
                continue;
            end
            chk("launch", 8'(start), 8'h01);
            wr(pa, 8'h00);
            chk("ee busy write", 8'(ew), 8'h00);
            wr(EEPROM_CONTROL, 8'h00);
            chk("zero no abort", 8'(start), 8'h01);
            wait_idle();
            rd(EEPROM_CONTROL);
            chk("page end ecr", v, 8'h00);
            rd(pa);
            chk("ee read back", v, pa[7:0] ^ 8'hA5);
        end
        wr(EEPROM_CONTROL, 8'h20);
        wr(EEPROM_CONTROL, 8'hA0);
        chk("erase all sel", 8'(eall), 8'h01);
        chk("erase all busy", 8'(eeprom_op_active), 8'h01);
        pulse(7);
        chk("skip old erase", 8'(skip), 8'h01);
        wait_idle();
        chk("skip cleared", 8'(skip), 8'h00);
        rd(EEPROM_CONTROL);
        chk("erase all end", v, 8'h00);
        wr(ST0, 8'h00);
        $display("test eeprom done");
        pulse(0);
        chk("flash busy", 8'(flash_op_active), 8'h01);
        rd(FA);
        chk("flash busy read", v, 8'hFF);
        wr(FA, 8'h00);
        chk("flash busy write", 8'(fw), 8'h00);
        pulse(3);
        chk("suspend", 8'(flash_op_active), 8'h00);
        rd(FA);
        chk("suspend read", v, FA[7:0] ^ 8'h5A);
        pulse(4);
        chk("resume", 8'(flash_op_active), 8'h01);
        pulse(2);
        wr(FA, 8'h00);
        chk("flash write", 8'(fw), 8'h01);
        pulse(1);
        chk("chip erase busy", 8'(flash_op_active), 8'h01);
        pulse(2);
        $display("test flash done");
        seed = lfsr(seed);
        sec <= seed[6:0] | 7'h01;
        pulse(9);
        rd(ST0);
        chk("fault sectors", v, {1'b1, sec});
        rd(ST1);
        chk("prog fault", v, 8'h40);
        pulse(8);
        rd(ST1);
        chk("erase fault", v, 8'hC0);
        pulse(5);
        rd(ST1);
        chk("overwrite fault", v, 8'hE0);
        wr(ST1, 8'h00);
        rd(ST1);
        chk("detail ro", v, 8'hE0);
        wr(ST0, 8'h00);
        rd(ST0);
        chk("sectors ro", v, {1'b0, sec});
        rd(ST1);
        chk("fault clear", v, 8'h00);
        pulse(7);
        rd(ST1);
        chk("swap fault", v, 8'h20);
        wr(ST0, 8'h00);
        $display("test status done");
        pin <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk("irq pin", 8'(irq), 8'h01);
        wr(EEPROM_CONTROL, 8'h02);
        chk("irq pin masked", 8'(irq), 8'h00);
        pin <= 1'b0;
        wr(EEPROM_CONTROL, 8'h00);
        pulse(10);
        @(posedge clk_i);
        #1;
        chk("standby", 8'(stby), 8'h01);
        pulse(12);
        wr(EEPROM_CONTROL, 8'h04);
        pulse(0);
        pulse(10);
        @(posedge clk_i);
        #1;
        chk("deferred", 8'(pdown), 8'h00);
        pulse(2);
        @(posedge clk_i);
        #1;
        chk("power down", 8'(pdown), 8'h01);
        pulse(12);
        chk("wake recovery", 8'(flash_op_active), 8'h01);
        wr(EEPROM_CONTROL, 8'h00);
        pulse(11);
        @(posedge clk_i);
        #1;
        chk("halt power down", 8'(pdown), 8'h01);
        $display("test power done");
        report_and_stop();
    end
endmodule
`default_nettype wire
